// ==== design/fwepc_top.sv ====
// flash write/erase sequencer with read protection, one wishbone classic slave
// assumes the cpu marks each access as direct or indirect, as fetch or data,
// and whether the issuing instruction runs from flash; flash array reads
// answer combinationally on flash_addr_o one cycle after it is set
//
// Contract
// R1: erase_select and write_enable_bit both set arm a bank erase, not started.
// R2: erase pulse generated internally, width from pulse_timer_setting.
// R3: software keeps erase pulse under 20 ms and total per bank under 30 s.
// R4: erase starts only on indirect write whose even address equals the data.
// R5: starting command sets operation_in_progress_flag; it clears when done.
// R6: erase completion enters erase_verify_mode automatically.
// R7: software programs the bank to all zeros before erasing.
// R8: erase_select 0 with write_enable_bit 1 arms programming, word_pair_select picks form.
// R9: software keeps program pulse at most 200 us, total per cell 2.5 ms.
// R10: single-word mode starts on one indirect write, address and data given.
// R11: pair mode latches first write, starts on second to same doubleword.
// R12: program completion enters program_verify_mode automatically.
// R13: verify modes read against margin; host reads twice 4 us apart.
// R14: software accepts erased ffff or programmed value on second verify read.
// R15: write_enable_bit written 0 leaves program/erase mode to non-verify mode.
// R16: non-verify mode serves ordinary reads; not while program/erase armed.
// R17: protection blocks data accesses and branches into flash from outside.
// R18: no erase or programming while protection is active.
// R19: protection active only when fuse and activation bit are both one.
// R20: fuse bit once one stays one; erase never touches it.
// R21: standard-mode direct write changes only activation bit, from flash code.
// R22: reset sets protection_activation_bit.
// R23: writing mode entered by dummy direct write then matching indirect write.
// R24: in writing mode direct even access hits register, indirect hits cell.
// R25: timer codes give 2^7, 2^11, 2^15, 2^18 cycle pulses.
// R26: bank codes 0..3 select the four documented address ranges.
//
// The implementer's own choices: the address map and register access over Wishbone.
module fwepc_top
	import fwepc_pkg::*;
#(
	parameter int P_EXP0 = PULSE_EXP0,
	parameter int P_EXP1 = PULSE_EXP1,
	parameter int P_EXP2 = PULSE_EXP2,
	parameter int P_EXP3 = PULSE_EXP3
) (
	input  wire logic          clk_i,             // cpu clock
	input  wire logic          rst_i,             // async reset, high
	input  wire logic          wb_cyc_i,          // bus cycle
	input  wire logic          wb_stb_i,          // strobe
	input  wire logic          wb_we_i,           // write
	input  wire logic [AW-1:0] wb_adr_i,          // flash byte address
	input  wire logic [1:0]    wb_sel_i,          // byte lanes
	input  wire logic [DW-1:0] wb_dat_i,          // write data
	output logic      [DW-1:0] wb_dat_o,          // read data
	output logic               wb_ack_o,          // done
	output logic               wb_err_o,          // refused
	input  wire logic          acc_direct_i,      // direct addressing
	input  wire logic          acc_fetch_i,       // fetch or branch target
	input  wire logic          acc_from_flash_i,  // issuer runs from flash
	input  wire logic          protection_fuse_i, // fuse cell state
	input  wire logic          vpp_ok_i,          // vpp above threshold
	input  wire logic [DW-1:0] flash_rdata_i,     // array read data
	output logic      [AW-1:0] flash_addr_o,      // array address
	output logic               flash_rd_o,        // array read strobe
	output logic      [31:0]   flash_wdata_o,     // program data hi:lo
	output logic               flash_pair_o,      // program both words
	output logic               flash_prog_o,      // program pulse
	output logic               flash_erase_o,     // erase pulse
	output logic      [1:0]    flash_bank_o,      // bank being erased
	output logic      [AW-1:0] flash_erase_lo_o,  // erase range start
	output logic      [AW-1:0] flash_erase_hi_o,  // erase range end
	output logic               flash_margin_o,    // margin read level
	output logic               prot_active_o,     // protection on
	output logic               writing_mode_o     // writing mode on
);

	localparam int CW = P_EXP3 + 1;

	if (P_EXP0 < 1 || P_EXP1 <= P_EXP0 || P_EXP2 <= P_EXP1 ||
		P_EXP3 <= P_EXP2 || P_EXP3 > 30) begin : g_bad_exp
		$error("fwepc_top: pulse exponents must rise and stay below 31");
	end

	function automatic logic [CW-1:0] pulse_last(input logic [1:0] code);
		logic [CW-1:0] one;
		one = {{(CW-1){1'b0}}, 1'b1};
		case (code)
			2'h0:    pulse_last = (one << P_EXP0) - one;
			2'h1:    pulse_last = (one << P_EXP1) - one;
			2'h2:    pulse_last = (one << P_EXP2) - one;
			default: pulse_last = (one << P_EXP3) - one;
		endcase
	endfunction

	function automatic logic [2*AW-1:0] bank_range(input logic [1:0] code);
		case (code)
			2'h0:    bank_range = {BANK0_HI, BANK0_LO};
			2'h1:    bank_range = {BANK1_HI, BANK1_LO};
			2'h2:    bank_range = {BANK2_HI, BANK2_LO};
			default: bank_range = {BANK3_HI, BANK3_LO};
		endcase
	endfunction

	// latched bus request
	logic          pend;
	logic          q_we;
	logic          q_dir;
	logic          q_ff;
	logic [AW-1:0] q_adr;
	logic [1:0]    q_sel;
	logic [DW-1:0] q_dat;

	// control register state
	logic       write_enable_bit;
	logic       fee;
	logic [1:0] pulse_timer_setting;
	logic       word_pair_select;
	logic [1:0] be;
	logic       protection_activation_bit;
	logic       wmode;
	logic       vppfail;
	logic       erase_verify_mode;
	logic       program_verify_mode;
	logic       fuse;

	// sequencing
	logic          unlock_arm;
	logic [DW-1:0] unlock_val;
	fwepc_op_t     op;
	fwepc_op_t     next_op;
	logic [CW-1:0] cnt;
	logic          op_erase;
	logic [DW-1:0] pair_lo;
	logic [AW-3:0] pair_adr;

	// decode of the latched request
	wire req      = wb_cyc_i & wb_stb_i & ~pend & ~wb_ack_o & ~wb_err_o;
	wire busy     = (op == OP_BUSY);
	wire verify   = erase_verify_mode | program_verify_mode;
	wire prot     = fuse & protection_activation_bit; // R19
	wire blocked  = prot & ~q_ff; // R17
	wire is_fcr   = wmode & q_dir; // R24
	wire adr_dat  = ({1'b0, q_adr} == q_dat);
	wire bad_shp  = wmode & (q_adr[0] | (q_sel != SEL_WORD));
	wire bad_busy = wmode & ~q_dir & ~q_we & busy;
	wire refuse   = blocked | bad_shp | bad_busy;
	wire ok       = pend & ~refuse;
	wire fcr_wr   = ok & is_fcr & q_we & ~busy;
	wire std_dwr  = ok & ~wmode & q_dir & q_we;
	wire unlock_hit = ok & ~wmode & unlock_arm & ~q_dir & q_we &
		~q_adr[0] & adr_dat & (q_dat == unlock_val); // R23

	// a command is an indirect write while armed; protection suppresses it
	wire cmd      = ok & wmode & ~q_dir & q_we & write_enable_bit & ~prot & ~busy; // R18
	wire erase_go = cmd & fee & adr_dat; // R4
	wire word_go  = cmd & ~fee & ~word_pair_select; // R10
	wire pair_go  = cmd & ~fee & word_pair_select & (op == OP_HALF) &
		(q_adr[AW-1:2] == pair_adr); // R11
	wire half_go  = cmd & ~fee & word_pair_select & ~pair_go;
	wire start    = erase_go | word_go | pair_go; // R1 R8
	wire pulse_end = busy & (cnt == {CW{1'b0}});

	// leaving program/erase mode drops the verify level as well
	wire vfy_clr  = start | (fcr_wr & (~q_dat[FCR_FWE] | ~q_dat[FCR_WMSET])); // R15

	logic [DW-1:0] fcr_rd;
	always_comb begin
		fcr_rd = RD_NONE;
		fcr_rd[FCR_FWE] = write_enable_bit;
		fcr_rd[FCR_FEE] = fee;
		fcr_rd[FCR_BUSY] = busy; // R5
		fcr_rd[FCR_VPPOK] = vpp_ok_i;
		fcr_rd[FCR_CK_HI:FCR_CK_LO] = pulse_timer_setting;
		fcr_rd[FCR_WORD_PAIR_SELECT] = word_pair_select;
		fcr_rd[FCR_BE_HI:FCR_BE_LO] = be;
		fcr_rd[FCR_VPPFAIL] = vppfail;
		fcr_rd[FCR_EVM] = erase_verify_mode;
		fcr_rd[FCR_PVM] = program_verify_mode;
		fcr_rd[FCR_WMSET] = wmode;
	end

	// armed but not yet verifying gives no cell data
	wire no_read = wmode & write_enable_bit & ~verify; // R16
	wire [DW-1:0] rd_mux = is_fcr  ? fcr_rd :
	                       no_read ? RD_NONE : flash_rdata_i;

	always_comb begin
		next_op = op;
		case (op)
			OP_IDLE: begin
				if (start)
					next_op = OP_BUSY;
				else if (half_go)
					next_op = OP_HALF;
			end
			OP_HALF: begin
				// any other access between the two halves abandons the pair
				if (pair_go)
					next_op = OP_BUSY;
				else if (half_go)
					next_op = OP_HALF;
				else if (pend)
					next_op = OP_IDLE;
			end
			OP_BUSY: begin
				if (pulse_end)
					next_op = OP_IDLE;
			end
			default: next_op = OP_IDLE;
		endcase
	end

	// bus front end: take, then answer one cycle later
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend  <= 1'b0;
			q_we  <= 1'b0;
			q_dir <= 1'b0;
			q_ff  <= 1'b0;
			q_adr <= '0;
			q_sel <= '0;
			q_dat <= '0;
		end else begin
			pend <= req;
			if (req) begin
				q_we  <= wb_we_i;
				q_dir <= acc_direct_i;
				q_ff  <= acc_from_flash_i;
				q_adr <= wb_adr_i;
				q_sel <= wb_sel_i;
				q_dat <= wb_dat_i;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= RD_NONE;
		end else begin
			wb_ack_o <= ok;
			wb_err_o <= pend & refuse; // R17
			if (ok & ~q_we)
				wb_dat_o <= rd_mux;
		end
	end

	// fetches carry no special path: a fetch is checked like a data access
	wire unused_fetch = acc_fetch_i;

	// fuse is sampled after release so reset itself loads only a constant
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			fuse <= 1'b0;
		else
			fuse <= fuse | protection_fuse_i | (unused_fetch & 1'b0); // R20
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			protection_activation_bit <= PROTECTION_ACTIVATION_BIT_RST; // R22
		else if (fcr_wr | (std_dwr & q_ff))
			protection_activation_bit <= q_dat[FCR_PROTECTION_ACTIVATION_BIT]; // R21
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			unlock_arm <= 1'b0;
			unlock_val <= '0;
		end else if (pend) begin
			unlock_arm <= std_dwr & ~q_adr[0]; // R23
			unlock_val <= q_dat;
		end
	end

	// writing mode and mode bits; the other bits ignore standard-mode writes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wmode <= 1'b0;
			write_enable_bit   <= 1'b0;
			fee   <= 1'b0;
			pulse_timer_setting <= '0;
			word_pair_select  <= 1'b0;
			be    <= '0;
		end else if (unlock_hit) begin
			wmode <= 1'b1; // R23
		end else if (fcr_wr) begin
			wmode <= q_dat[FCR_WMSET];
			write_enable_bit   <= q_dat[FCR_FWE] & q_dat[FCR_WMSET];
			fee   <= q_dat[FCR_FEE];
			pulse_timer_setting <= q_dat[FCR_CK_HI:FCR_CK_LO];
			word_pair_select  <= q_dat[FCR_WORD_PAIR_SELECT];
			be    <= q_dat[FCR_BE_HI:FCR_BE_LO];
		end
	end

	// verify levels: completion set wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			erase_verify_mode <= 1'b0;
			program_verify_mode <= 1'b0;
		end else if (pulse_end) begin
			erase_verify_mode <= op_erase; // R6
			program_verify_mode <= ~op_erase; // R12
		end else if (vfy_clr) begin
			erase_verify_mode <= 1'b0;
			program_verify_mode <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			vppfail <= 1'b0;
		else if (busy & ~vpp_ok_i)
			vppfail <= 1'b1;
		else if (start)
			vppfail <= 1'b0;
	end

	// operation sequencer and pulse timer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op  <= OP_IDLE;
			cnt <= '0;
		end else begin
			op <= next_op; // R5
			if (start)
				cnt <= pulse_last(pulse_timer_setting); // R2 R25
			else if (busy & ~pulse_end)
				cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pair_lo  <= '0;
			pair_adr <= '0;
		end else if (half_go) begin
			pair_lo  <= q_dat; // R11
			pair_adr <= q_adr[AW-1:2];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_erase      <= 1'b0;
			flash_prog_o  <= 1'b0;
			flash_erase_o <= 1'b0;
			flash_pair_o  <= 1'b0;
			flash_wdata_o <= '0;
		end else if (start) begin
			op_erase      <= erase_go;
			flash_prog_o  <= ~erase_go;
			flash_erase_o <= erase_go; // R1 R2
			flash_pair_o  <= pair_go;
			flash_wdata_o <= pair_go ? {q_dat, pair_lo} : {RD_NONE, q_dat}; // R10 R11
		end else if (pulse_end) begin
			flash_prog_o  <= 1'b0;
			flash_erase_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flash_bank_o     <= '0;
			flash_erase_lo_o <= '0;
			flash_erase_hi_o <= '0;
		end else if (erase_go) begin
			flash_bank_o <= be;
			{flash_erase_hi_o, flash_erase_lo_o} <= bank_range(be); // R26
		end
	end

	wire [2*AW-1:0] erase_rng = bank_range(be); // R26

	// the array address follows the bus except while a pulse is applied
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flash_addr_o <= '0;
			flash_rd_o   <= 1'b0;
		end else begin
			flash_rd_o <= req & ~wb_we_i & ~busy;
			if (start)
				flash_addr_o <= erase_go ? erase_rng[AW-1:0] :
				                pair_go  ? {pair_adr, 2'h0} : q_adr;
			else if (req & ~busy)
				flash_addr_o <= wb_adr_i;
		end
	end

	// settle time between the two verify reads is left to software
	assign flash_margin_o = verify; // R13
	assign prot_active_o  = prot;
	assign writing_mode_o = wmode;

endmodule

// ==== design/fwepc_pkg.sv ====
// constants, field layout and types of the flash write/erase/protect controller
// assumes a 16-bit cpu data path and a 32 kbyte flash window (15-bit byte address)
package fwepc_pkg;

	localparam int AW = 15;
	localparam int DW = 16;

	// control register bit positions
	localparam int FCR_FWE     = 0;
	localparam int FCR_FEE     = 1;
	localparam int FCR_BUSY    = 2;
	localparam int FCR_PROTECTION_ACTIVATION_BIT   = 3;
	localparam int FCR_VPPOK   = 4;
	localparam int FCR_CK_LO   = 5;
	localparam int FCR_CK_HI   = 6;
	localparam int FCR_WORD_PAIR_SELECT    = 7;
	localparam int FCR_BE_LO   = 8;
	localparam int FCR_BE_HI   = 9;
	localparam int FCR_VPPFAIL = 11;
	localparam int FCR_EVM     = 12;
	localparam int FCR_PVM     = 13;
	localparam int FCR_WMSET   = 15;

	localparam logic PROTECTION_ACTIVATION_BIT_RST = 1'b1;

	// pulse lengths are 2^exp cpu clock cycles
	localparam int PULSE_EXP0 = 7;
	localparam int PULSE_EXP1 = 11;
	localparam int PULSE_EXP2 = 15;
	localparam int PULSE_EXP3 = 18;

	localparam logic [AW-1:0] BANK0_LO = 15'h0000;
	localparam logic [AW-1:0] BANK0_HI = 15'h2fff;
	localparam logic [AW-1:0] BANK1_LO = 15'h3000;
	localparam logic [AW-1:0] BANK1_HI = 15'h5fff;
	localparam logic [AW-1:0] BANK2_LO = 15'h6000;
	localparam logic [AW-1:0] BANK2_HI = 15'h77ff;
	localparam logic [AW-1:0] BANK3_LO = 15'h7800;
	localparam logic [AW-1:0] BANK3_HI = 15'h7fff;

	localparam logic [1:0]    SEL_WORD = 2'h3;
	localparam logic [DW-1:0] RD_NONE  = 16'h0000;

	typedef enum logic [1:0] {
		OP_IDLE = 2'h0,
		OP_HALF = 2'h1,
		OP_BUSY = 2'h3
	} fwepc_op_t;

endpackage

// ==== dv/fwepc_top_monitor.sv ====
// concurrent checks on the ports of the flash write/erase/protect controller
// assumes one clock domain and an asynchronous active-high reset
module fwepc_top_monitor #(
	parameter int P_EXP0 = 7,
	parameter int P_EXP1 = 11,
	parameter int P_EXP2 = 15,
	parameter int P_EXP3 = 18
) (
	input wire logic clk_i,             // cpu clock
	input wire logic rst_i,             // async reset
	input wire logic wb_cyc_i,          // bus cycle
	input wire logic wb_stb_i,          // strobe
	input wire logic wb_ack_o,          // done
	input wire logic wb_err_o,          // refused
	input wire logic acc_from_flash_i,  // issuer in flash
	input wire logic protection_fuse_i, // fuse state
	input wire logic flash_prog_o,      // program pulse
	input wire logic flash_erase_o,     // erase pulse
	input wire logic flash_margin_o,    // verify level
	input wire logic prot_active_o      // protection on
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int W0 = 1 << P_EXP0;
	localparam int W1 = 1 << P_EXP1;
	localparam int W2 = 1 << P_EXP2;
	localparam int W3 = 1 << P_EXP3;
	int   wid;
	logic fuse_seen;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// one counter serves both pulses since they never overlap
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wid <= 0;
			fuse_seen <= 1'b0;
		end else begin
			wid <= (flash_prog_o || flash_erase_o) ? wid + 1 : 0;
			fuse_seen <= fuse_seen | protection_fuse_i;
		end
	end
	property p_ans;
		$rose(wb_stb_i) && wb_cyc_i |-> ##2 (wb_ack_o || wb_err_o);
	endproperty
	a_ans: assert property (p_ans) else $error("no answer two edges after request");
	property p_pulse;
		wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
	property p_block;
		$rose(wb_stb_i) && wb_cyc_i && prot_active_o && !acc_from_flash_i |-> ##2 wb_err_o;
	endproperty
	a_block: assert property (p_block) else $error("outside access not refused");
	property p_noop;
		$rose(flash_prog_o) || $rose(flash_erase_o) |-> !$past(prot_active_o);
	endproperty
	a_noop: assert property (p_noop) else $error("operation started while protected");
	property p_fuse;
		!fuse_seen |-> !prot_active_o;
	endproperty
	a_fuse: assert property (p_fuse) else $error("protection on without fuse");
	property p_rst;
		$fell(rst_i) && protection_fuse_i |=> prot_active_o;
	endproperty
	a_rst: assert property (p_rst) else $error("protection off after reset");
	property p_width;
		$fell(flash_prog_o) || $fell(flash_erase_o) |-> wid == W0 || wid == W1 || wid == W2
			|| wid == W3;
	endproperty
	a_width: assert property (p_width) else $error("pulse width not a timer length");
	property p_evm;
		$fell(flash_erase_o) |-> ##[0:1] flash_margin_o;
	endproperty
	a_evm: assert property (p_evm) else $error("no verify level after erase");
	property p_pvm;
		$fell(flash_prog_o) |-> ##[0:1] flash_margin_o;
	endproperty
	a_pvm: assert property (p_pvm) else $error("no verify level after program");
	property p_excl;
		!(flash_prog_o && flash_erase_o);
	endproperty
	a_excl: assert property (p_excl) else $error("program and erase together");
	c_prog: cover property ($rose(flash_prog_o));
	c_erase: cover property ($rose(flash_erase_o));
	c_err: cover property (wb_err_o);
endmodule

bind fwepc_top fwepc_top_monitor #(.P_EXP0(P_EXP0), .P_EXP1(P_EXP1), .P_EXP2(P_EXP2),
	.P_EXP3(P_EXP3)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.acc_from_flash_i(acc_from_flash_i), .protection_fuse_i(protection_fuse_i),
	.flash_prog_o(flash_prog_o), .flash_erase_o(flash_erase_o),
	.flash_margin_o(flash_margin_o), .prot_active_o(prot_active_o));

// ==== dv/fwepc_flash_model.sv ====
// behavioural flash array behind the controller
// assumes pulses are levels and the address holds the target while they run
module fwepc_flash_model
	import fwepc_pkg::*;
(
	input  wire logic          clk_i,   // cpu clock
	input  wire logic [AW-1:0] addr_i,  // array address
	input  wire logic [31:0]   wdata_i, // program data
	input  wire logic          pair_i,  // both words
	input  wire logic          prog_i,  // program pulse
	input  wire logic          erase_i, // erase pulse
	input  wire logic [AW-1:0] lo_i,    // erase start
	input  wire logic [AW-1:0] hi_i,    // erase end
	output logic      [DW-1:0] rdata_o  // read data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [DW-1:0] mem [0:16383];
	logic          prog_q;
	logic          erase_q;
	initial begin
		prog_q = 1'b0;
		erase_q = 1'b0;
		foreach (mem[i]) mem[i] = 16'h0000;
	end
	assign rdata_o = mem[addr_i[AW-1:1]];
	always @(posedge clk_i) begin
		prog_q <= prog_i;
		erase_q <= erase_i;
		if (prog_i && !prog_q && pair_i) begin
			mem[{addr_i[AW-1:2], 1'b0}] <= wdata_i[15:0];
			mem[{addr_i[AW-1:2], 1'b1}] <= wdata_i[31:16];
		end else if (prog_i && !prog_q) begin
			mem[addr_i[AW-1:1]] <= wdata_i[15:0];
		end
		if (erase_i && !erase_q) begin
			for (int i = lo_i[AW-1:1]; i <= hi_i[AW-1:1]; i++) mem[i] <= 16'hffff;
		end
	end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the flash write/erase/protect controller
// assumes the flash model answers array reads and a 100 MHz clock
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module tb_top
	import fwepc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic          clk_i, rst_i, cyc, stb, we, dir, fch, ffl, fuse, er;
	logic          ack, err, fprog, ferase, fpair, margin, prot, wmode;
	logic [1:0]    sel, bnk;
	logic [AW-1:0] adr, faddr, elo, ehi;
	logic [DW-1:0] wdat, rdat, fdat, rd;
	logic [31:0]   fwd;
	int            n_fail, check_count, cyc_cnt;
	fwepc_top #(.P_EXP0(1), .P_EXP1(2), .P_EXP2(3), .P_EXP3(4)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .acc_direct_i(dir), .acc_fetch_i(fch),
		.acc_from_flash_i(ffl), .protection_fuse_i(fuse), .vpp_ok_i(1'b1),
		.flash_rdata_i(fdat), .flash_addr_o(faddr), .flash_rd_o(), .flash_wdata_o(fwd),
		.flash_pair_o(fpair), .flash_prog_o(fprog), .flash_erase_o(ferase),
		.flash_bank_o(bnk), .flash_erase_lo_o(elo), .flash_erase_hi_o(ehi),
		.flash_margin_o(margin), .prot_active_o(prot), .writing_mode_o(wmode));
	fwepc_flash_model u_flash (.clk_i(clk_i), .addr_i(faddr), .wdata_i(fwd), .pair_i(fpair),
		.prog_i(fprog), .erase_i(ferase), .lo_i(elo), .hi_i(ehi), .rdata_o(fdat));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	// request held until the answer edge, then released for one idle cycle
	task automatic wb(input logic w, d, f, input logic [AW-1:0] a, input logic [DW-1:0] v);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		dir <= d;
		ffl <= f;
		adr <= a;
		wdat <= v;
		// no local limit: only the bench timeout ends a hung wait
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1 && err !== 1'b1);
		rd = rdat;
		er = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic idle();
		int n;
		n = 0;
		do begin
			wb(0, 1, 0, 15'h0000, 16'h0000);
			n++;
		end while (rd[2] !== 1'b0 && n < 40);
		`CHK(rd[2], 1'b0)
	endtask
	task automatic vread(input logic [AW-1:0] a);
		wb(0, 0, 0, a, 16'h0000);
		repeat (400) @(posedge clk_i);
		wb(0, 0, 0, a, 16'h0000);
	endtask
	task automatic t_prot();
		wb(0, 0, 0, 15'h0100, 16'h0000);
		`CHK(er, 1'b1)
		`CHK(prot, 1'b1)
		wb(1, 1, 1, 15'h0010, 16'h0010);
		`CHK(prot, 1'b0)
		wb(1, 0, 0, 15'h0010, 16'h0010);
		`CHK(wmode, 1'b1)
		$display("test prot_unlock done");
	endtask
	task automatic t_prog();
		wb(1, 1, 0, 15'h0000, 16'h8001);
		wb(0, 0, 0, 15'h0100, 16'h0000);
		`CHK(rd, 16'h0000)
		wb(1, 0, 0, 15'h0100, 16'h1234);
		idle();
		`CHK(rd[13], 1'b1)
		`CHK(margin, 1'b1)
		vread(15'h0100);
		`CHK(rd, 16'h1234)
		wb(0, 0, 0, 15'h0101, 16'h0000);
		`CHK(er, 1'b1)
		$display("test program_word done");
	endtask
	task automatic t_pair();
		wb(1, 1, 0, 15'h0000, 16'h80a1);
		wb(1, 0, 0, 15'h0200, 16'h1111);
		wb(0, 0, 0, 15'h0100, 16'h0000);
		wb(1, 0, 0, 15'h0200, 16'haaaa);
		// any access between the halves drops the pair, so watch the pin instead
		`CHK(fprog, 1'b0)
		wb(1, 0, 0, 15'h0200, 16'h5555);
		idle();
		vread(15'h0200);
		`CHK(rd, 16'haaaa)
		vread(15'h0202);
		`CHK(rd, 16'h5555)
		$display("test program_pair done");
	endtask
	task automatic t_erase();
		wb(1, 1, 0, 15'h0000, 16'h8363);
		wb(1, 0, 0, 15'h7800, 16'h1234);
		`CHK(ferase, 1'b0)
		wb(0, 1, 0, 15'h0000, 16'h0000);
		`CHK(rd[2], 1'b0)
		wb(1, 0, 0, 15'h7800, 16'h7800);
		wb(0, 1, 0, 15'h0000, 16'h0000);
		`CHK(rd[2], 1'b1)
		`CHK(elo, BANK3_LO)
		`CHK(ehi, BANK3_HI)
		`CHK(bnk, 2'h3)
		idle();
		`CHK(rd[12], 1'b1)
		vread(15'h7ffe);
		`CHK(rd, 16'hffff)
		vread(15'h77fe);
		`CHK(rd, 16'h0000)
		$display("test erase done");
	endtask
	task automatic t_exit();
		wb(1, 1, 0, 15'h0000, 16'h8000);
		wb(0, 1, 0, 15'h0000, 16'h0000);
		`CHK(rd[12], 1'b0)
		`CHK(margin, 1'b0)
		wb(0, 0, 0, 15'h0100, 16'h0000);
		`CHK(rd, 16'h1234)
		wb(1, 1, 0, 15'h0000, 16'h8001);
		wb(0, 0, 0, 15'h0100, 16'h0000);
		`CHK(rd, 16'h0000)
		wb(1, 1, 0, 15'h0000, 16'h0000);
		`CHK(wmode, 1'b0)
		$display("test exit done");
	endtask
	task automatic t_refuse();
		fuse <= 1'b0;
		wb(1, 1, 1, 15'h0008, 16'h0008);
		`CHK(prot, 1'b1)
		wb(1, 0, 1, 15'h0008, 16'h0008);
		wb(1, 1, 1, 15'h0000, 16'h8009);
		wb(1, 0, 1, 15'h0300, 16'h5678);
		`CHK(fprog, 1'b0)
		wb(0, 1, 1, 15'h0000, 16'h0000);
		`CHK(rd[2], 1'b0)
		$display("test protected_refusal done");
	endtask
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, dir, fch, ffl} = 6'h00;
		fuse = 1'b1;
		sel = SEL_WORD;
		adr = 15'h0000;
		wdat = 16'h0000;
		n_fail = 0;
		check_count = 0;
		cyc_cnt = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_prot();
		t_prog();
		t_pair();
		t_erase();
		t_exit();
		t_refuse();
		print_verdict();
	end
endmodule
